// ### design/trc_pkg.sv
package trc_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TRC_RELOAD_VALUE_ADDR = 8'h00_CD;
  localparam logic [7:0] TRC_CLOCK_OPTION_ADDR = 8'h00_D8;
  localparam logic [7:0] TRC_MODE_CONTROL_ADDR = 8'h00_DA;
  localparam logic [7:0] TRC_COUNT_VALUE_ADDR  = 8'h00_DB;
  localparam logic [7:0] TRC_STATUS_ADDR       = 8'h00_DC;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int TRC_GREEN_WAKE_BIT  = 1;
  localparam int TRC_FAST_CLOCK_BIT  = 2;
  localparam int TRC_SECOND_X8_BIT   = 3;
  localparam int TRC_PWM_OUT_BIT     = 0;
  localparam int TRC_TOGGLE_OUT_BIT  = 1;
  localparam int TRC_RELOAD_EN_BIT   = 2;
  localparam int TRC_EXT_SRC_BIT     = 3;
  localparam int TRC_RATE_LSB        = 4;
  localparam int TRC_ENABLE_BIT      = 7;
  localparam int TRC_OVF_FLAG_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] TRC_BYTE_RESET   = 8'h00_00;
  localparam logic [7:0] TRC_CLKOPT_MASK  = 8'h00_0E;
  localparam logic [7:0] TRC_MASK_256     = 8'h00_FF;
  localparam logic [7:0] TRC_MASK_64      = 8'h00_3F;
  localparam logic [7:0] TRC_MASK_32      = 8'h00_1F;
  localparam logic [7:0] TRC_MASK_16      = 8'h00_0F;
  localparam logic [7:0] TRC_COUNT_ONE    = 8'h00_01;
  localparam logic [7:0] TRC_PRESCALE_MAX = 8'h00_FF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } trc_bus_type;

  typedef struct packed {
    logic [7:0] clock_option;
    logic [7:0] mode_control;
    logic [7:0] count_value;
    logic [7:0] reload_hold;
    logic [7:0] reload_active;
    logic [7:0] prescale;
    logic       overflow_flag;
    logic       hosc_tick_a;
    logic       hosc_tick_b;
    logic       hosc_last;
    logic       ext_sync_a;
    logic       ext_sync_b;
    logic       ext_last;
    logic       wake;
    logic [7:0] rdata;
  } trc_state_type;

endpackage

// ### design/trc_timer.sv
// Functional notes
// - Fast-clock bit selects oscillator instead of instruction clock into prescaler.
// - Clock option bit 1 enables green-mode wake-up.
// - Event counter mode ignores fast-clock bit and prescaler select.
// - 8-bit count; overflow sets sticky flag until software clears it.
// - Overflow reloads the count from the reload register only in PWM mode or with the reload bit set.
// - PWM mode overflows every 256/64/32/16 counts by reload/toggle bits.
// - Reduced PWM boundaries use only low count and reload bits.
// - No PWM or event mode: boundary is full 256 counts.
// - Reload writes go to holding buffer, moved to active on overflow.
// - PWM mode always reloads; reload bit selects boundary instead.
// - Event mode counts falling edges of the external pin.
// - Event mode overflows when a falling edge finds the count at 0xFF.
// - Event mode blocks pin wake-up function.
// - Event mode blocks pin interrupt; pin flag held at zero.
// - Timer counts only while enable bit 7 is set; reset zero.
// - Prescale codes 000..111 divide 256..2 or 128..1.
// - Mode bit 3 selects external pin as clock source.
// - Green mode keeps counting; wakes on overflow only if enabled.
module trc_timer
  import trc_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  input  wire logic       HOSC_TICK,
  input  wire logic       EVENT_PIN,
  input  wire logic       GREEN_MODE,
  input  wire logic       PIN_WAKE_REQ,
  input  wire logic       PIN_IRQ_REQ,
  output logic            OVERFLOW_FLAG,
  output logic            OVERFLOW_PULSE,
  output logic            GREEN_WAKE,
  output logic            PIN_WAKE,
  output logic            PIN_IRQ_FLAG
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  trc_state_type state_ff;
  trc_state_type nxt_state;
  trc_bus_type   bus;

  logic       enabled;
  logic       event_mode;
  logic       pwm_mode;
  logic       fast_clock;
  logic [2:0] rate;
  logic [7:0] bound_mask;
  logic [7:0] div_mask;
  logic       base_tick;
  logic       count_tick;
  logic       overflow;
  logic [7:0] count_next;

  // Edge detects
  logic       hosc_rise;
  logic       ext_fall;

  // Register strobes
  logic       wr_reload;
  logic       wr_clock_option;
  logic       wr_mode;
  logic       wr_count;
  logic       wr_status;
  logic       flag_clear;

  // Next values
  logic       reload_on_ovf;
  logic [7:0] load_value;
  logic [7:0] read_value;
  logic       flag_next;
  logic       wake_next;

  // Bus signals bundled
  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  // ----------------------------------------------------------------
  // Register bus decode
  // ----------------------------------------------------------------
  // Write strobes per register
  assign wr_reload       = bus.wr && (bus.addr == TRC_RELOAD_VALUE_ADDR);
  assign wr_clock_option = bus.wr && (bus.addr == TRC_CLOCK_OPTION_ADDR);
  assign wr_mode         = bus.wr && (bus.addr == TRC_MODE_CONTROL_ADDR);
  assign wr_count        = bus.wr && (bus.addr == TRC_COUNT_VALUE_ADDR);
  assign wr_status       = bus.wr && (bus.addr == TRC_STATUS_ADDR);

  // Writing 0 to the flag bit clears it
  assign flag_clear = wr_status && !bus.wdata[TRC_OVF_FLAG_BIT];

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------
  // Decoded configuration
  assign enabled    = state_ff.mode_control[TRC_ENABLE_BIT];
  assign event_mode = state_ff.mode_control[TRC_EXT_SRC_BIT];
  assign pwm_mode   = state_ff.mode_control[TRC_PWM_OUT_BIT];
  assign fast_clock = state_ff.clock_option[TRC_FAST_CLOCK_BIT];
  assign rate       = state_ff.mode_control[TRC_RATE_LSB +: 3];

  // ----------------------------------------------------------------
  // Overflow boundary
  // ----------------------------------------------------------------
  // Boundary mask from reload and toggle bits in PWM mode only
  always_comb
  begin
    bound_mask = TRC_MASK_256;
    if (pwm_mode && !event_mode)
    begin
      case ({state_ff.mode_control[TRC_RELOAD_EN_BIT], state_ff.mode_control[TRC_TOGGLE_OUT_BIT]})
        2'b01:   bound_mask = TRC_MASK_64;
        2'b10:   bound_mask = TRC_MASK_32;
        2'b11:   bound_mask = TRC_MASK_16;
        default: bound_mask = TRC_MASK_256;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Clock base and prescaler
  // ----------------------------------------------------------------
  // Divider mask: code 0 divides most, code 7 least
  always_comb
  begin
    if (fast_clock)
    begin
      div_mask = TRC_PRESCALE_MAX >> ({1'b0, rate} + 4'd1);
    end
    else
    begin
      div_mask = TRC_PRESCALE_MAX >> rate;
    end
  end

  // Oscillator tick edge; one prescaler step per tick, not per cycle
  assign hosc_rise = state_ff.hosc_tick_b && !state_ff.hosc_last;

  // Instruction clock is CLK itself
  assign base_tick = fast_clock ? hosc_rise : 1'b1;

  // Falling edge of the synchronised event pin
  assign ext_fall = state_ff.ext_last && !state_ff.ext_sync_b;

  // Count tick per source
  always_comb
  begin
    if (event_mode)
    begin
      count_tick = ext_fall;
    end
    else
    begin
      count_tick = base_tick && ((state_ff.prescale & div_mask) == div_mask);
    end
  end

  // Masked increment and overflow detect
  assign count_next = (state_ff.count_value + TRC_COUNT_ONE) & bound_mask;
  assign overflow   = enabled && count_tick
                      && ((state_ff.count_value & bound_mask) == bound_mask);

  // ----------------------------------------------------------------
  // Reload selection
  // ----------------------------------------------------------------
  // PWM forces reload; otherwise the reload bit decides
  assign reload_on_ovf = pwm_mode || state_ff.mode_control[TRC_RELOAD_EN_BIT];

  // Value taken by the counter at overflow
  always_comb
  begin
    if (reload_on_ovf)
    begin
      load_value = state_ff.reload_hold & bound_mask;
    end
    else
    begin
      load_value = count_next;
    end
  end

  // ----------------------------------------------------------------
  // Overflow flag and wake
  // ----------------------------------------------------------------
  // Set wins over a same-cycle software clear
  always_comb
  begin
    if (overflow)
    begin
      flag_next = 1'b1;
    end
    else if (flag_clear)
    begin
      flag_next = 1'b0;
    end
    else
    begin
      flag_next = state_ff.overflow_flag;
    end
  end

  // Wake pulse only for overflow in green mode with wake enabled
  assign wake_next = overflow && GREEN_MODE && state_ff.clock_option[TRC_GREEN_WAKE_BIT];

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  // Unmapped and write-only addresses read zero
  always_comb
  begin
    if (bus.addr == TRC_CLOCK_OPTION_ADDR)
    begin
      read_value = state_ff.clock_option;
    end
    else if (bus.addr == TRC_MODE_CONTROL_ADDR)
    begin
      read_value = state_ff.mode_control;
    end
    else if (bus.addr == TRC_COUNT_VALUE_ADDR)
    begin
      read_value = state_ff.count_value;
    end
    else if (bus.addr == TRC_STATUS_ADDR)
    begin
      read_value = {7'd0, state_ff.overflow_flag};
    end
    else
    begin
      read_value = TRC_BYTE_RESET;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;

    // Synchronisers
    nxt_state.ext_sync_a  = EVENT_PIN;
    nxt_state.ext_sync_b  = state_ff.ext_sync_a;
    nxt_state.ext_last    = state_ff.ext_sync_b;
    nxt_state.hosc_tick_a = HOSC_TICK;
    nxt_state.hosc_tick_b = state_ff.hosc_tick_a;
    nxt_state.hosc_last   = state_ff.hosc_tick_b;

    // Prescaler runs while enabled on internal source
    if (!enabled || event_mode)
    begin
      nxt_state.prescale = TRC_BYTE_RESET;
    end
    else if (base_tick)
    begin
      nxt_state.prescale = state_ff.prescale + TRC_COUNT_ONE;
    end

    // Counting and reload
    if (enabled && count_tick)
    begin
      if (overflow)
      begin
        nxt_state.reload_active = state_ff.reload_hold;
        nxt_state.count_value   = load_value;
      end
      else
      begin
        nxt_state.count_value = count_next;
      end
    end

    // Sticky flag and wake pulse
    nxt_state.overflow_flag = flag_next;
    nxt_state.wake          = wake_next;

    // Register writes; a count write beats the reload
    if (wr_reload)
    begin
      nxt_state.reload_hold = bus.wdata;
    end
    else if (wr_clock_option)
    begin
      nxt_state.clock_option = bus.wdata & TRC_CLKOPT_MASK;
    end
    else if (wr_mode)
    begin
      nxt_state.mode_control = bus.wdata;
    end
    else if (wr_count)
    begin
      nxt_state.count_value = bus.wdata;
    end

    // Read data registered, zero outside the read slot
    if (bus.rd)
    begin
      nxt_state.rdata = read_value;
    end
    else
    begin
      nxt_state.rdata = TRC_BYTE_RESET;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Registered data, flag and wake; overflow pulse is combinational
  assign RDATA          = state_ff.rdata;
  assign OVERFLOW_FLAG  = state_ff.overflow_flag;
  assign OVERFLOW_PULSE = overflow;
  assign GREEN_WAKE     = state_ff.wake;

  // ----------------------------------------------------------------
  // Pin gating
  // ----------------------------------------------------------------
  // Event counting owns the pin: no wake, no pin interrupt
  assign PIN_WAKE       = PIN_WAKE_REQ && !event_mode;
  assign PIN_IRQ_FLAG   = PIN_IRQ_REQ && !event_mode;

endmodule

// ### testbench/trc_timer_chk.sv
module trc_chk
  import trc_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic       WR,
  input wire logic       RD,
  input wire logic [7:0] RDATA,
  input wire logic       GREEN_MODE,
  input wire logic       PIN_WAKE_REQ,
  input wire logic       PIN_IRQ_REQ,
  input wire logic       OVERFLOW_FLAG,
  input wire logic       OVERFLOW_PULSE,
  input wire logic       GREEN_WAKE,
  input wire logic       PIN_WAKE,
  input wire logic       PIN_IRQ_FLAG
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mode_ff;
  logic       wake_en_ff;
  logic       clr_req;

  // Shadow of mode register and wake enable
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      mode_ff    <= 8'h00_00;
      wake_en_ff <= 1'b0;
    end
    else if (WR && ADDR == TRC_MODE_CONTROL_ADDR)
      mode_ff <= WDATA;
    else if (WR && ADDR == TRC_CLOCK_OPTION_ADDR)
      wake_en_ff <= WDATA[TRC_GREEN_WAKE_BIT];
  end

  // Software clear of the overflow flag
  assign clr_req = WR && ADDR == TRC_STATUS_ADDR && !WDATA[TRC_OVF_FLAG_BIT];

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  flag_set_a: assert property (OVERFLOW_PULSE |=> OVERFLOW_FLAG)
    else $error("overflow flag not set");
  flag_hold_a: assert property (OVERFLOW_FLAG && !clr_req |=> OVERFLOW_FLAG)
    else $error("overflow flag dropped by itself");
  flag_clear_a: assert property (clr_req && !OVERFLOW_PULSE |=> !OVERFLOW_FLAG)
    else $error("overflow flag not cleared");
  irq_block_a: assert property (PIN_IRQ_FLAG == (PIN_IRQ_REQ && !mode_ff[TRC_EXT_SRC_BIT]))
    else $error("pin interrupt flag wrong");
  wake_block_a: assert property (PIN_WAKE == (PIN_WAKE_REQ && !mode_ff[TRC_EXT_SRC_BIT]))
    else $error("pin wake wrong");
  green_wake_a: assert property (GREEN_WAKE == $past(OVERFLOW_PULSE && GREEN_MODE && wake_en_ff))
    else $error("green wake wrong");
  read_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00_00)
    else $error("read data outside read slot");
  reload_wo_a: assert property ($past(RD && ADDR == TRC_RELOAD_VALUE_ADDR) |-> RDATA == 8'h00_00)
    else $error("reload register readable");
  stop_a: assert property (!mode_ff[TRC_ENABLE_BIT] |-> !OVERFLOW_PULSE)
    else $error("overflow while disabled");
  pulse_gap_a: assert property (OVERFLOW_PULSE |=> !OVERFLOW_PULSE)
    else $error("overflow faster than half clock");
endmodule

bind trc_timer trc_chk trc_chk_i (.*);

// ### testbench/tb_top.sv
module tb_top
  import trc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK = 1'b0, RST_N = 1'b0, WR = 1'b0, RD = 1'b0, HOSC_TICK = 1'b0, EVENT_PIN = 1'b1;
  logic        GREEN_MODE = 1'b0, PIN_WAKE_REQ = 1'b1, PIN_IRQ_REQ = 1'b1;
  logic        OVERFLOW_FLAG, OVERFLOW_PULSE, GREEN_WAKE, PIN_WAKE, PIN_IRQ_FLAG;
  logic [7:0]  ADDR = 8'h00_00, WDATA = 8'h00_00, RDATA;
  int          errors = 0, total_checks = 0, wakes = 0, hosc_cnt = 0, n;
  logic [7:0]  opt[7] = '{8'h00_00, 8'h00_00, 8'h00_00, 8'h00_00, 8'h00_00, 8'h00_04, 8'h00_04};
  logic [7:0]  md[7]  = '{8'h00_F1, 8'h00_F3, 8'h00_F5, 8'h00_F7, 8'h00_F6, 8'h00_F6, 8'h00_E6};
  logic [15:0] per[7] = '{16'd240, 16'd112, 16'd48, 16'd16, 16'd240, 16'd960, 16'd1920};

  trc_timer trc_timer_i (.*);

  // Clock, oscillator ticks every 8 cycles, green wake counter
  always #2.5 CLK = ~CLK;
  always @(posedge CLK)
  begin
    hosc_cnt <= hosc_cnt + 1;
    HOSC_TICK <= hosc_cnt[2];
    if (GREEN_WAKE === 1'b1)
      wakes <= wakes + 1;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    @(negedge CLK);
    check(RDATA, exp);
  endtask

  // Cycles up to and including the next overflow pulse
  task automatic ovf();
    n = 0;
    do
    begin
      @(negedge CLK);
      n++;
    end
    while (OVERFLOW_PULSE !== 1'b1 && n < 4000);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    #400_000;
    errors++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge CLK);
    RST_N <= 1'b1;
    rdc(TRC_COUNT_VALUE_ADDR, 8'h00_00);
    rdc(TRC_MODE_CONTROL_ADDR, 8'h00_00);
    rdc(TRC_CLOCK_OPTION_ADDR, 8'h00_00);
    wr(TRC_CLOCK_OPTION_ADDR, 8'h00_FF);
    rdc(TRC_CLOCK_OPTION_ADDR, 8'h00_0E);
    wr(TRC_RELOAD_VALUE_ADDR, 8'h00_5A);
    rdc(TRC_RELOAD_VALUE_ADDR, 8'h00_00);
    rdc(8'h00_E0, 8'h00_00);
    wr(TRC_COUNT_VALUE_ADDR, 8'h00_FF);
    wr(TRC_MODE_CONTROL_ADDR, 8'h00_70);
    repeat (40) @(posedge CLK);
    rdc(TRC_COUNT_VALUE_ADDR, 8'h00_FF);
    $display("register test done");
    for (int i = 0; i < 7; i++)
    begin
      wr(TRC_MODE_CONTROL_ADDR, 8'h00_00);
      wr(TRC_CLOCK_OPTION_ADDR, opt[i]);
      wr(TRC_COUNT_VALUE_ADDR, 8'h00_88);
      wr(TRC_RELOAD_VALUE_ADDR, 8'h00_88);
      wr(TRC_MODE_CONTROL_ADDR, md[i]);
      ovf();
      ovf();
      check(16'(n), per[i]);
    end
    wr(TRC_CLOCK_OPTION_ADDR, 8'h00_00);
    wr(TRC_RELOAD_VALUE_ADDR, 8'h00_C8);
    ovf();
    ovf();
    check(16'(n), 16'd224);
    wr(TRC_MODE_CONTROL_ADDR, 8'h00_00);
    rdc(TRC_STATUS_ADDR, 8'h00_01);
    wr(TRC_STATUS_ADDR, 8'h00_01);
    rdc(TRC_STATUS_ADDR, 8'h00_01);
    wr(TRC_STATUS_ADDR, 8'h00_00);
    rdc(TRC_STATUS_ADDR, 8'h00_00);
    $display("period test done");
    GREEN_MODE <= 1'b1;
    wr(TRC_CLOCK_OPTION_ADDR, 8'h00_06);
    wr(TRC_COUNT_VALUE_ADDR, 8'h00_FE);
    wr(TRC_RELOAD_VALUE_ADDR, 8'h00_10);
    wr(TRC_MODE_CONTROL_ADDR, 8'h00_FC);
    repeat (6)
    begin
      repeat (4) @(posedge CLK);
      EVENT_PIN <= ~EVENT_PIN;
    end
    repeat (8) @(posedge CLK);
    rdc(TRC_COUNT_VALUE_ADDR, 8'h00_11);
    check(PIN_IRQ_FLAG, 1'b0);
    check(PIN_WAKE, 1'b0);
    check(16'(wakes), 16'd1);
    rdc(TRC_STATUS_ADDR, 8'h00_01);
    wr(TRC_MODE_CONTROL_ADDR, 8'h00_00);
    rdc(TRC_COUNT_VALUE_ADDR, 8'h00_11);
    check(PIN_IRQ_FLAG, 1'b1);
    check(PIN_WAKE, 1'b1);
    $display("event test done");
    stop_test();
  end
endmodule
